// ---- common/sys_timer_pkg.sv ----
/*
 * Constants shared by the system timer: counter and window geometry,
 * clock divider reset value, read selector codes and compare field widths.
 * Assumes nothing of its surroundings beyond a SystemVerilog compiler.
 */
package sys_timer_pkg;

    // ========================================================
    // counter geometry
    localparam int CNT_W     = 56;
    localparam int WIN_W     = 32;
    localparam int WIN_STEP  = 4;
    localparam int HI_LSB    = 32;
    localparam int HI_W      = CNT_W - HI_LSB;
    localparam int LOW_WINS  = 6;

    // ========================================================
    // read selector codes
    localparam int            SEL_W       = 3;
    localparam logic [2:0]    SEL_TOP_WIN = 3'h6;
    localparam logic [2:0]    SEL_CAPTURE = 3'h7;

    // ========================================================
    // clock divider
    localparam int            DIV_W       = 3;
    localparam logic [2:0]    DIV_RESET   = 3'h2;
    localparam logic [2:0]    DIV_OFF     = 3'h0;

    // ========================================================
    // compare fields: start bit and size-minus-one of the compared range
    localparam int            CMP_N       = 2;
    localparam int            CMP_START_W = 6;
    localparam int            CMP_SIZE_W  = 5;

endpackage : sys_timer_pkg

// ---- rtl/timer_tick_gen.sv ----
/*
 * Timer clock enable generator: one pulse every div_i system clocks.
 * Assumes div_i, run_i and restart_i come from logic on the same clock.
 */
`timescale 1ns/10ps
module timer_tick_gen
    import sys_timer_pkg::*;
(
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             rstn_i,
    // control
    input  wire logic             run_i,
    input  wire logic             restart_i,
    input  wire logic [DIV_W-1:0] div_i,
    // timer clock enable
    output logic                  tick_o
);

    typedef struct packed {
        logic [DIV_W-1:0] pre;
        logic             tick;
    } tick_s;

    tick_s s;
    tick_s next_s;

    // ========================================================
    // prescaler
    always_comb begin
        next_s      = s;
        next_s.tick = 1'b0;
        // divider value zero stops the timer clock altogether
        if (!run_i || restart_i || div_i == DIV_OFF) begin
            next_s.pre = '0;
        end else if (s.pre >= div_i - 3'h1) begin
            next_s.pre  = '0;
            next_s.tick = 1'b1;
        end else begin
            next_s.pre = s.pre + 3'h1;
        end
    end

    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign tick_o = s.tick;

endmodule : timer_tick_gen

// ---- rtl/sys_timer.sv ----
/*
 * Free-running 56-bit system timer with divided clock, seven read windows,
 * an upper-count capture and two partial-range compare interrupts.
 * Assumes rstn_i is the power-on reset; the other reset sources and the
 * hardware reset pin arrive asynchronously and are synchronised here.
 * Control and read requests come from logic on clk_i.
 */
`timescale 1ns/10ps
module sys_timer
    import sys_timer_pkg::*;
(
    // clock and power-on reset
    input  wire logic                   clk_i,
    input  wire logic                   rstn_i,
    // asynchronous reset sources
    input  wire logic                   hardware_reset_pin_n_i,
    input  wire logic                   watchdog_reset_i,
    input  wire logic                   software_reset_i,
    input  wire logic                   timer_reset_request_bit_i,
    // clock control write
    input  wire logic                   clock_ctrl_wr_i,
    input  wire logic                   clock_ctrl_disable_i,
    input  wire logic                   clock_ctrl_suspend_i,
    input  wire logic [DIV_W-1:0]       clock_ctrl_divider_i,
    // read request
    input  wire logic                   rd_i,
    input  wire logic [SEL_W-1:0]       rd_sel_i,
    // compare setup
    input  wire logic [WIN_W-1:0]       compare_value_0_i,
    input  wire logic [WIN_W-1:0]       compare_value_1_i,
    input  wire logic [CMP_START_W-1:0] cmp_start_0_i,
    input  wire logic [CMP_START_W-1:0] cmp_start_1_i,
    input  wire logic [CMP_SIZE_W-1:0]  cmp_size_0_i,
    input  wire logic [CMP_SIZE_W-1:0]  cmp_size_1_i,
    input  wire logic [CMP_N-1:0]       cmp_irq_en_i,
    // read answer
    output logic [WIN_W-1:0]            rd_data_o,
    output logic                        rd_valid_o,
    // status
    output logic                        timer_running_o,
    output logic [DIV_W-1:0]            timer_clock_divider_o,
    output logic [CMP_N-1:0]            cmp_irq_o
);

    // ========================================================
    // state
    typedef struct packed {
        logic [2:0]       sync1;
        logic [2:0]       sync2;
        logic [CNT_W-1:0] count;
        logic [HI_W-1:0]  capture;
        logic [DIV_W-1:0] divider;
        logic             disabled;
        logic             suspended;
        logic             running;
        logic [CMP_N-1:0] hit;
        logic [CMP_N-1:0] irq;
        logic [WIN_W-1:0] rd_data;
        logic             rd_valid;
    } timer_s;

    timer_s s;
    timer_s next_s;

    logic tick;
    logic hw_reset;
    logic clear;

    // ========================================================
    // synchroniser lanes
    localparam int         HW_PIN_LANE = 0;
    localparam int         WDOG_LANE   = 1;
    localparam int         SW_LANE     = 2;
    // the pin lane idles high, so reset leaves no false hardware reset
    localparam logic [2:0] SYNC_IDLE   = 3'h1;

    // ========================================================
    // helpers
    function automatic logic [WIN_W-1:0] zext_hi(
        input logic [HI_W-1:0] hi
    );
        zext_hi = {{(WIN_W-HI_W){1'b0}}, hi};
    endfunction : zext_hi

    // only the six finer windows load the capture
    function automatic logic is_low_window(
        input logic [SEL_W-1:0] idx
    );
        is_low_window = int'(idx) < LOW_WINS;
    endfunction : is_low_window

    function automatic logic [WIN_W-1:0] read_window(
        input logic [CNT_W-1:0] cnt,
        input logic [SEL_W-1:0] idx
    );
        logic [CNT_W-1:0] sh;
        sh = '0;
        if (idx == SEL_TOP_WIN) begin
            read_window = zext_hi(cnt[CNT_W-1:HI_LSB]);
        end else begin
            sh          = cnt >> (WIN_STEP * int'(idx));
            read_window = sh[WIN_W-1:0];
        end
    endfunction : read_window

    function automatic logic cmp_match(
        input logic [CNT_W-1:0]       cnt,
        input logic [WIN_W-1:0]       val,
        input logic [CMP_START_W-1:0] start,
        input logic [CMP_SIZE_W-1:0]  size
    );
        logic [CNT_W-1:0] sh;
        logic [WIN_W:0]   mask;
        sh   = cnt >> start;
        mask = (33'h1 << (int'(size) + 1)) - 33'h1;
        cmp_match = ((sh[WIN_W-1:0] ^ val) & mask[WIN_W-1:0]) == '0;
    endfunction : cmp_match

    // ========================================================
    // reset sources after synchronisation
    assign hw_reset = !s.sync2[HW_PIN_LANE];
    // software reset only counts when its request bit is set
    assign clear    = s.sync2[WDOG_LANE] || (s.sync2[SW_LANE] && timer_reset_request_bit_i);

    // ========================================================
    // timer clock
    timer_tick_gen u_tick (
        .clk_i     (clk_i),
        .rstn_i    (rstn_i),
        .run_i     (s.running),
        .restart_i (clear),
        .div_i     (s.divider),
        .tick_o    (tick)
    );

    // ========================================================
    // next state
    always_comb begin
        logic [1:0] m;
        m = '0;

        next_s       = s;
        next_s.sync1 = {software_reset_i, watchdog_reset_i, hardware_reset_pin_n_i};
        next_s.sync2 = s.sync1;

        // clock control
        if (clock_ctrl_wr_i) begin
            next_s.disabled  = clock_ctrl_disable_i;
            next_s.suspended = clock_ctrl_suspend_i;
            next_s.divider   = clock_ctrl_divider_i;
        end
        // hardware reset only returns the gating bits to run
        if (hw_reset) begin
            next_s.disabled  = 1'b0;
            next_s.suspended = 1'b0;
        end

        // counter has no write path at all
        if (clear) begin
            next_s.count     = '0;
            next_s.divider   = DIV_RESET;
            next_s.disabled  = 1'b0;
            next_s.suspended = 1'b0;
        end else if (tick) begin
            next_s.count = s.count + 56'h1;
        end
        next_s.running = !next_s.disabled && !next_s.suspended;

        // reads are served whatever the gating state
        next_s.rd_valid = rd_i;
        if (rd_i) begin
            if (rd_sel_i == SEL_CAPTURE) begin
                next_s.rd_data = zext_hi(s.capture);
            end else begin
                next_s.rd_data = read_window(s.count, rd_sel_i);
            end
            // capture the same count the window shows
            if (is_low_window(rd_sel_i)) begin
                next_s.capture = s.count[CNT_W-1:HI_LSB];
            end
        end

        // compare: interrupt pulse on the first cycle of a match
        m[0]       = cmp_match(s.count, compare_value_0_i, cmp_start_0_i, cmp_size_0_i);
        m[1]       = cmp_match(s.count, compare_value_1_i, cmp_start_1_i, cmp_size_1_i);
        next_s.hit = m;
        next_s.irq = m & ~s.hit & cmp_irq_en_i;
    end

    // ========================================================
    // registers; power-on reset clears everything but sync1, sync2 (idle), divider (DIV_RESET) and running (set)
    always_ff @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            s          <= '0;
            s.sync1    <= SYNC_IDLE;
            s.sync2    <= SYNC_IDLE;
            s.divider  <= DIV_RESET;
            s.running  <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    // ========================================================
    // outputs
    assign rd_data_o             = s.rd_data;
    assign rd_valid_o            = s.rd_valid;
    assign timer_running_o       = s.running;
    assign timer_clock_divider_o = s.divider;
    assign cmp_irq_o             = s.irq;

endmodule : sys_timer

// ---- tb/sys_timer_checker.sv ----
/* port assertions for sys_timer, bound at the foot.
 * assumes sys_timer_pkg is compiled first. */
`timescale 1ns/10ps
module sys_timer_checker
    import sys_timer_pkg::*;
(
    // =====
    // watched ports
    input wire logic             clk_i,
    input wire logic             rstn_i,
    input wire logic             hardware_reset_pin_n_i,
    input wire logic             watchdog_reset_i,
    input wire logic             software_reset_i,
    input wire logic             clock_ctrl_wr_i,
    input wire logic             clock_ctrl_suspend_i,
    input wire logic [DIV_W-1:0] clock_ctrl_divider_i,
    input wire logic             rd_i,
    input wire logic [SEL_W-1:0] rd_sel_i,
    input wire logic [CMP_N-1:0] cmp_irq_en_i,
    input wire logic [WIN_W-1:0] rd_data_o,
    input wire logic             rd_valid_o,
    input wire logic             timer_running_o,
    input wire logic [DIV_W-1:0] timer_clock_divider_o,
    input wire logic [CMP_N-1:0] cmp_irq_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    a_rd_answer: assert property (rd_i |=> rd_valid_o) else $error("read unanswered");
    a_rd_pulse: assert property (!rd_i |=> !rd_valid_o) else $error("stray valid");
    a_top_zero: assert property (rd_valid_o && $past(rd_sel_i) > 3'h5 |-> rd_data_o[31:24] == 8'h0)
        else $error("top window not zero-extended");
    // reset sources act two edges late, through the synchroniser
    a_div_load: assert property (clock_ctrl_wr_i
        && !$past(watchdog_reset_i, 2) && !$past(software_reset_i, 2)
        |=> timer_clock_divider_o == $past(clock_ctrl_divider_i)) else $error("divider not loaded");
    a_div_keep: assert property (!clock_ctrl_wr_i
        && !$past(watchdog_reset_i, 2) && !$past(software_reset_i, 2)
        |=> $stable(timer_clock_divider_o)) else $error("divider changed");
    a_suspend_stop: assert property (clock_ctrl_wr_i && clock_ctrl_suspend_i
        && $past(hardware_reset_pin_n_i, 2) && !$past(watchdog_reset_i, 2) && !$past(software_reset_i, 2)
        |=> !timer_running_o) else $error("still running");
    a_irq_pulse: assert property (cmp_irq_o[0] |=> !cmp_irq_o[0]) else $error("irq not a pulse");
    a_irq_mask: assert property (cmp_irq_o[1] |-> $past(cmp_irq_en_i[1])) else $error("masked irq");
    a_reset_up: assert property ($rose(rstn_i) |-> timer_running_o && timer_clock_divider_o == DIV_RESET)
        else $error("bad state after reset");
endmodule : sys_timer_checker
bind sys_timer sys_timer_checker i_sys_timer_checker (.*);

// ---- tb/tb.sv ----
/* self-checking bench for sys_timer: dividers, stop modes, windows,
 * resets and compares. assumes sys_timer_pkg is compiled first. */
`timescale 1ns/10ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_errors++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb;
    import sys_timer_pkg::*;
    // =====
    // design signals, all driven from time zero
    logic clk_i = 1'b0, rstn_i = 1'b0, hardware_reset_pin_n_i = 1'b1, watchdog_reset_i = 1'b0;
    logic software_reset_i = 1'b0, timer_reset_request_bit_i = 1'b0, clock_ctrl_wr_i = 1'b0, rd_i = 1'b0;
    logic clock_ctrl_disable_i = 1'b0, clock_ctrl_suspend_i = 1'b0, rd_valid_o, timer_running_o, hit, oth;
    logic [DIV_W-1:0] clock_ctrl_divider_i = 3'h2, timer_clock_divider_o, d;
    logic [SEL_W-1:0] rd_sel_i = 3'h0;
    logic [WIN_W-1:0] compare_value_0_i = 32'h0, compare_value_1_i = 32'h0, rd_data_o, a, b, c;
    logic [CMP_START_W-1:0] cmp_start_0_i = 6'h0, cmp_start_1_i = 6'h4;
    logic [CMP_SIZE_W-1:0] cmp_size_0_i = 5'h1f, cmp_size_1_i = 5'h3;
    logic [CMP_N-1:0] cmp_irq_en_i = 2'h0, cmp_irq_o;
    int n_errors = 0, n_compared = 0, cycles = 0, seed = 72156, k;
    sys_timer i_sys_timer (.*);
    always #50 clk_i = ~clk_i;
    // hang guard, the run needs under 3000 cycles
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            final_report();
        end
    end
    // =====
    // helpers
    task automatic step(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask : step
    task automatic rd(input logic [2:0] s, output logic [WIN_W-1:0] v);
        rd_i = 1'b1;
        rd_sel_i = s;
        step(1);
        rd_i = 1'b0;
        v = rd_data_o;
        `CHK(rd_valid_o, 1'b1)
        step(1);
    endtask : rd
    task automatic ctl(input logic dis, input logic sus, input logic [2:0] dv);
        clock_ctrl_wr_i = 1'b1;
        {clock_ctrl_disable_i, clock_ctrl_suspend_i, clock_ctrl_divider_i} = {dis, sus, dv};
        step(1);
        clock_ctrl_wr_i = 1'b0;
        step(1);
    endtask : ctl
    task automatic wait_irq(input int j);
        hit = 1'b0;
        oth = 1'b0;
        repeat (100) begin
            step(1);
            hit |= cmp_irq_o[j];
            oth |= cmp_irq_o[1-j];
        end
        `CHK(hit, 1'b1)
        `CHK(oth, 1'b0)
    endtask : wait_irq
    function automatic logic [31:0] win(input logic [CNT_W-1:0] v, input int n);
        return (n < 6) ? v[4*n +: 32] : {8'h0, v[55:32]};
    endfunction : win
    task automatic final_report();
        $display("compared %0d, mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : final_report
    // =====
    // main sequence
    initial begin
        step(4);
        rstn_i = 1'b1;
        `CHK(timer_clock_divider_o, DIV_RESET)
        `CHK(timer_running_o, 1'b1)
        for (k = 0; k < 6; k++) begin
            d = (k == 0) ? 3'h1 : (k == 1) ? 3'h7 : 3'(1 + {$random(seed)} % 7);
            ctl(1'b0, 1'b0, d);
            `CHK(timer_clock_divider_o, d)
            rd(3'h0, a);
            step(8 * d - 2);
            rd(3'h0, b);
            `CHK(b - a, 32'h8)
        end
        $display("test rate done");
        // divider zero, suspend, disable
        for (k = 0; k < 3; k++) begin
            ctl(k == 2, k == 1, (k == 0) ? 3'h0 : 3'h3);
            rd(3'h0, a);
            step(20);
            rd(3'h0, b);
            `CHK(b, a)
            `CHK(timer_running_o, 1'(k == 0))
        end
        $display("test stop modes done");
        // frozen count gives a fixed reference for every window
        rd(3'h0, a);
        rd(3'h6, c);
        for (k = 0; k < 8; k++) begin
            rd(3'(k), b);
            `CHK(b, win({c[23:0], a}, k))
        end
        $display("test windows done");
        ctl(1'b0, 1'b1, 3'h5);
        rd(3'h0, a);
        hardware_reset_pin_n_i = 1'b0;
        step(6);
        hardware_reset_pin_n_i = 1'b1;
        step(20);
        `CHK(timer_clock_divider_o, 3'h5)
        rd(3'h0, b);
        `CHK(b > a, 1'b1)
        // software reset unqualified, qualified, then watchdog
        for (k = 0; k < 3; k++) begin
            ctl(1'b0, 1'b0, 3'h1);
            timer_reset_request_bit_i = (k == 1);
            software_reset_i = (k < 2);
            watchdog_reset_i = (k == 2);
            step(6);
            rd(3'h0, b);
            `CHK(b == 0, k > 0)
            `CHK(timer_clock_divider_o, (k > 0) ? DIV_RESET : 3'h1)
            software_reset_i = 1'b0;
            watchdog_reset_i = 1'b0;
            step(8);
            rd(3'h0, c);
            `CHK(c != 0, 1'b1)
        end
        $display("test resets done");
        ctl(1'b0, 1'b0, 3'h1);
        rd(3'h0, a);
        compare_value_0_i = a + 32'd40;
        compare_value_1_i = a + 32'd40;
        cmp_irq_en_i = 2'h1;
        wait_irq(0);
        rd(3'h0, a);
        compare_value_1_i = {$random(seed)};
        compare_value_1_i[3:0] = a[7:4] + 4'h3;
        cmp_irq_en_i = 2'h2;
        wait_irq(1);
        $display("test compare done");
        final_report();
    end
endmodule : tb
